/* File: src/fpe_flash_ctrl.sv */
`timescale 1ns/1ps
`include "fpe_map.svh"
module fpe_flash_ctrl (
  fpe_if.dev bus,
  input wire logic test_mode,
  input wire logic run_abort,
  input wire logic [15:0] array_rdata,
  output logic array_rd,
  output logic reg_mode,
  output logic run_active,
  output logic op_go,
  output fpe_pkg::fpe_op_e op_sel,
  output fpe_pkg::fpe_margin_e margin_sel,
  output logic [7:0] sector_enables,
  output logic [15:0] program_address_latch,
  output logic [15:0] program_data_latch,
  output logic [`FPE_TEST_W-1:0] flash_test
);
  logic reg_mode_q, reg_mode_d;
  logic [15:0] ctrl_q, ctrl_d;
  logic [15:0] addr_q, addr_d;
  logic [15:0] data_q, data_d;
  logic [`FPE_TEST_W-1:0] test_q, test_d;
  logic [15:0] rdata_q, rdata_d;
  logic abort_s1_q, abort_q;
  wire clk_w = bus.clk;
  wire arst_w = bus.arst_n;

  wire io_hit = bus.io_sel && (bus.addr == `FPE_IO_PORT);
  wire io_out = io_hit && bus.wr;
  wire io_in = io_hit && bus.rd;
  wire [1:0] off = bus.addr[1:0]; // [RULE3]
  wire reg_wr = bus.mem_sel && bus.wr && reg_mode_q;
  wire reg_rd = bus.mem_sel && bus.rd && reg_mode_q;
  wire arr_wr = bus.mem_sel && bus.wr && !reg_mode_q && !ctrl_q[`FPE_RUN_BIT]; // [RULE14]
  wire arr_rd = bus.mem_sel && bus.rd && !reg_mode_q && !ctrl_q[`FPE_RUN_BIT]; // [RULE14]
  wire wr_ctrl = reg_wr && (off == `FPE_OFF_CTRL); // [RULE4]
  wire wr_test = reg_wr && (off == `FPE_OFF_TEST) && test_mode; // [RULE15]
  wire wr_addr = reg_wr && (off == `FPE_OFF_ADDR) && !ctrl_q[`FPE_RUN_BIT];
  wire wr_data = reg_wr && (off == `FPE_OFF_DATA) && !ctrl_q[`FPE_RUN_BIT];
  wire running = ctrl_q[`FPE_RUN_BIT];
  wire key_ok = (bus.wdata[`FPE_KEY_LSB+:2] == `FPE_KEY_UNLOCK); // [RULE9]
  wire run_new = bus.wdata[`FPE_RUN_BIT] && (running || key_ok); // [RULE9] [RULE13]
  wire [1:0] op_f = ctrl_q[`FPE_OP_LSB+:2];
  wire [1:0] mrg_f = ctrl_q[`FPE_MRG_LSB+:2];
  wire [7:0] sec_f = ctrl_q[`FPE_SEC_LSB+:8];
  wire op_defined = (op_f != fpe_pkg::FPE_OP_NONE); // [RULE7]
  wire erase_like = (op_f == fpe_pkg::FPE_OP_ERASE);
  wire fill_ok = !erase_like || (data_q == `FPE_ERASE_FILL); // [RULE18]
  wire [15:0] ctrl_rd = {sec_f, 1'b0, 2'b00, mrg_f, op_f, running}; // [RULE10] [RULE19]
  wire [15:0] test_rd = test_mode ? {11'h000, test_q} : 16'h0000; // [RULE15]
  wire [15:0] reg_rd_val = (off == `FPE_OFF_CTRL) ? ctrl_rd :
                           (off == `FPE_OFF_TEST) ? test_rd :
                           (off == `FPE_OFF_ADDR) ? addr_q : data_q;

  always_comb begin
    reg_mode_d = reg_mode_q;
    if (io_out) begin
      reg_mode_d = 1'b1; // [RULE1]
    end else if (io_in) begin
      reg_mode_d = 1'b0; // [RULE2]
    end
  end

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      if (running) begin
        // frozen: only run and op bits follow the write
        ctrl_d[`FPE_OP_LSB+:2] = bus.wdata[`FPE_OP_LSB+:2]; // [RULE12]
        ctrl_d[`FPE_RUN_BIT] = run_new;
      end else begin
        ctrl_d[`FPE_SEC_LSB+:8] = bus.wdata[`FPE_SEC_LSB+:8]; // [RULE11]
        ctrl_d[`FPE_MRG_LSB+:2] = bus.wdata[`FPE_MRG_LSB+:2]; // [RULE8]
        ctrl_d[`FPE_OP_LSB+:2] = bus.wdata[`FPE_OP_LSB+:2]; // [RULE7]
        ctrl_d[`FPE_RUN_BIT] = run_new; // [RULE9]
      end
    end
    ctrl_d[7:5] = 3'b000; // [RULE10] [RULE19]
  end

  always_comb begin
    addr_d = addr_q;
    data_d = data_q;
    if (arr_wr) begin
      addr_d = bus.addr; // [RULE16]
      data_d = bus.wdata; // [RULE17]
    end
    if (wr_addr) begin
      addr_d = bus.wdata; // [RULE16]
    end
    if (wr_data) begin
      data_d = bus.wdata; // [RULE17]
    end
  end

  assign test_d = wr_test ? bus.wdata[`FPE_TEST_W-1:0] : test_q;

  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      rdata_d = reg_rd_val;
    end else if (arr_rd) begin
      rdata_d = array_rdata;
    end else if (bus.mem_sel && bus.rd) begin
      rdata_d = 16'h0000; // [RULE14]
    end
  end

  always_ff @(posedge clk_w or negedge arst_w) begin
    if (!arst_w) begin
      abort_s1_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      abort_s1_q <= run_abort;
      abort_q <= abort_s1_q;
    end
  end

  always_ff @(posedge clk_w or negedge arst_w) begin
    if (!arst_w) begin
      reg_mode_q <= 1'b0;
      ctrl_q <= `FPE_CTRL_RESET; // [RULE5]
      addr_q <= 16'h0000;
      data_q <= 16'h0000;
      test_q <= '0;
      rdata_q <= 16'h0000;
    end else begin
      reg_mode_q <= reg_mode_d;
      ctrl_q <= ctrl_d;
      addr_q <= addr_d;
      data_q <= data_d;
      test_q <= test_d;
      rdata_q <= rdata_d;
    end
  end

  // array is altered only with a legal, unlocked, unaborted setup
  assign op_go = running && !abort_q && op_defined && (sec_f != 8'h00) &&
                 (mrg_f == fpe_pkg::FPE_MRG_NORMAL) && fill_ok; // [RULE6] [RULE18]
  assign op_sel = fpe_pkg::fpe_op_e'(op_f);
  assign margin_sel = fpe_pkg::fpe_margin_e'(mrg_f);
  assign sector_enables = sec_f; // [RULE11]
  assign program_address_latch = addr_q;
  assign program_data_latch = data_q;
  assign flash_test = test_q;
  assign reg_mode = reg_mode_q;
  assign run_active = running;
  assign array_rd = arr_rd;
  assign bus.rdata = rdata_q;
endmodule

/* File: common/fpe_map.svh */
// How it works
// RULE1: io write to port ff0f enters register mode
// RULE2: io read from port ff0f restores array mode
// RULE3: register mode decodes two low address bits
// RULE4: offsets: control 0, test 1, address 2, data 3
// RULE5: reset clears the whole sector control register
// RULE6: start needs legal op, key, sectors, no abort
// RULE7: op field 2..1: none, erase, write, recovery
// RULE8: margin field 4..3 selects read sense mode
// RULE9: run only sets with key 10 same write
// RULE10: key bits always read back as zero
// RULE11: each sector enable gates its own sector
// RULE12: run set freezes sector and margin bits
// RULE13: software clears run without the key
// RULE14: run locks latches and ignores array accesses
// RULE15: test register invisible outside test mode
// RULE16: address latch loads from array write or register
// RULE17: data latch loads from array write or register
// RULE18: erase starts only with data latch ffff
// RULE19: bit 7 reserved, reads zero, ignores writes
`ifndef FPE_MAP_SVH
`define FPE_MAP_SVH
`define FPE_IO_PORT 16'hff0f
`define FPE_OFF_CTRL 2'h0
`define FPE_OFF_TEST 2'h1
`define FPE_OFF_ADDR 2'h2
`define FPE_OFF_DATA 2'h3
`define FPE_CTRL_RESET 16'h0000
`define FPE_RUN_BIT 0
`define FPE_OP_LSB 1
`define FPE_MRG_LSB 3
`define FPE_KEY_LSB 5
`define FPE_SEC_LSB 8
`define FPE_KEY_UNLOCK 2'h2
`define FPE_ERASE_FILL 16'hffff
`define FPE_TEST_W 5
`endif

/* File: common/fpe_pkg.sv */
package fpe_pkg;
  typedef enum logic [1:0] {
    FPE_OP_NONE = 2'b00,
    FPE_OP_ERASE = 2'b01,
    FPE_OP_WRITE = 2'b10,
    FPE_OP_RECOVER = 2'b11
  } fpe_op_e;
  typedef enum logic [1:0] {
    FPE_MRG_NORMAL = 2'b00,
    FPE_MRG_ONES = 2'b01,
    FPE_MRG_ZEROS = 2'b10,
    FPE_MRG_DEPLETION = 2'b11
  } fpe_margin_e;
  typedef enum logic [1:0] {
    FPE_CMD_IO_OUT = 2'b00,
    FPE_CMD_IO_IN = 2'b01,
    FPE_CMD_MEM_WR = 2'b10,
    FPE_CMD_MEM_RD = 2'b11
  } fpe_cmd_e;
endpackage

/* File: common/fpe_if.sv */
`timescale 1ns/1ps
interface fpe_if (
  input wire logic clk,
  input wire logic arst_n
);
  logic io_sel;
  logic mem_sel;
  logic wr;
  logic rd;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport dev (
    input clk, arst_n, io_sel, mem_sel, wr, rd, addr, wdata,
    output rdata
  );
  modport core (
    input clk, arst_n, rdata,
    output io_sel, mem_sel, wr, rd, addr, wdata
  );
endinterface

/* File: src/fpe_core_port.sv */
`timescale 1ns/1ps
`include "fpe_map.svh"
module fpe_core_port (
  fpe_if.core bus,
  input wire logic cmd_valid,
  input fpe_pkg::fpe_cmd_e cmd_kind,
  input wire logic [15:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data
);
  typedef enum logic [1:0] {
    FPE_ST_IDLE = 2'b00,
    FPE_ST_DRIVE = 2'b01,
    FPE_ST_CAPTURE = 2'b10
  } fpe_st_e;

  fpe_st_e st_q, st_d;
  fpe_pkg::fpe_cmd_e kind_q;
  logic [15:0] addr_q, wdata_q, rsp_q;
  logic rsp_v_q;

  wire clk_w = bus.clk;
  wire arst_w = bus.arst_n;
  wire take = cmd_valid && (st_q == FPE_ST_IDLE);
  wire is_io = (kind_q == fpe_pkg::FPE_CMD_IO_OUT) || (kind_q == fpe_pkg::FPE_CMD_IO_IN);
  wire is_wr = (kind_q == fpe_pkg::FPE_CMD_IO_OUT) || (kind_q == fpe_pkg::FPE_CMD_MEM_WR);
  wire drive = (st_q == FPE_ST_DRIVE);

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      FPE_ST_IDLE: if (take) st_d = FPE_ST_DRIVE;
      FPE_ST_DRIVE: st_d = FPE_ST_CAPTURE;
      FPE_ST_CAPTURE: st_d = FPE_ST_IDLE;
      default: st_d = FPE_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_w or negedge arst_w) begin
    if (!arst_w) begin
      st_q <= FPE_ST_IDLE;
      kind_q <= fpe_pkg::FPE_CMD_MEM_RD;
      addr_q <= 16'h0000;
      wdata_q <= 16'h0000;
      rsp_q <= 16'h0000;
      rsp_v_q <= 1'b0;
    end else begin
      st_q <= st_d;
      rsp_v_q <= (st_q == FPE_ST_CAPTURE);
      if (take) begin
        kind_q <= cmd_kind;
        addr_q <= cmd_addr;
        wdata_q <= cmd_wdata;
      end
      if (st_q == FPE_ST_CAPTURE) begin
        rsp_q <= bus.rdata;
      end
    end
  end

  // io out / io in to the mode port switch the device mode
  assign bus.io_sel = drive && is_io; // [RULE1] [RULE2]
  assign bus.mem_sel = drive && !is_io;
  assign bus.wr = drive && is_wr;
  assign bus.rd = drive && !is_wr;
  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q; // [RULE9] [RULE13]
  assign cmd_ready = (st_q == FPE_ST_IDLE);
  assign rsp_valid = rsp_v_q;
  assign rsp_data = rsp_q;
endmodule

/* File: testbench/fpe_chk.sv */
`timescale 1ns/1ps
module fpe_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic io_sel,
  input wire logic mem_sel,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata
);
  logic mode_q, run_q;
  logic [15:0] ctl_q, adr_q, dat_q;
  wire mw = mem_sel && wr;
  wire mr = mem_sel && rd;
  wire al = mw && !run_q && !mode_q;
  wire cw = mode_q && mw && addr[1:0] == 2'h0;
  wire r0 = mode_q && mr && addr[1:0] == 2'h0;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= 1'b0;
      run_q <= 1'b0;
      ctl_q <= 16'h0;
      adr_q <= 16'h0;
      dat_q <= 16'h0;
    end else begin
      if (io_sel && wr && addr == 16'hff0f) mode_q <= 1'b1;
      if (io_sel && rd && addr == 16'hff0f) mode_q <= 1'b0;
      if (cw) run_q <= wdata[0] && (run_q || wdata[6:5] == 2'h2);
      if (cw) ctl_q <= run_q ? {ctl_q[15:8], 3'h0, ctl_q[4:3], wdata[2:1], 1'b0}
                             : {wdata[15:8], 3'h0, wdata[4:1], 1'b0};
      if (al) adr_q <= addr;
      if (al) dat_q <= wdata;
      if (mw && mode_q && !run_q && addr[1:0] == 2'h2) adr_q <= wdata;
      if (mw && mode_q && !run_q && addr[1:0] == 2'h3) dat_q <= wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_ctl; r0 |=> rdata == {ctl_q[15:1], run_q}; endproperty
  a_ctl: assert property (p_ctl) else $error("control readback");
  property p_key; r0 |=> rdata[7:5] == 3'h0; endproperty
  a_key: assert property (p_key) else $error("key bits read");
  property p_alias; r0 && addr[15:2] != 14'h0 |=> rdata[0] == run_q; endproperty
  a_alias: assert property (p_alias) else $error("alias read");
  property p_rst; $rose(arst_n) |-> rdata == 16'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset read data");
  property p_adr; mode_q && mr && addr[1:0] == 2'h2 |=> rdata == adr_q; endproperty
  a_adr: assert property (p_adr) else $error("address latch");
  property p_dat; mode_q && mr && addr[1:0] == 2'h3 |=> rdata == dat_q; endproperty
  a_dat: assert property (p_dat) else $error("data latch");
  property p_tst; mode_q && mr && addr[1:0] == 2'h1 |=> rdata == 16'h0; endproperty
  a_tst: assert property (p_tst) else $error("test reg visible");
  property p_busy; !mode_q && mr && run_q |=> rdata == 16'h0; endproperty
  a_busy: assert property (p_busy) else $error("array read while run");
endmodule

/* File: testbench/tb_flash_program_erase_control.sv */
`timescale 1ns/1ps
module tb_flash_program_erase_control;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid = 1'b0;
  fpe_pkg::fpe_cmd_e cmd_kind = fpe_pkg::FPE_CMD_IO_OUT;
  logic [15:0] cmd_addr = 16'h0;
  logic [15:0] cmd_wdata = 16'h0;
  logic run_abort = 1'b0;
  logic cmd_ready, rsp_valid, reg_mode, run_active, op_go;
  logic [15:0] rsp_data, pal, pdl;
  fpe_pkg::fpe_op_e op_sel;
  fpe_pkg::fpe_margin_e margin_sel;
  logic [7:0] sector_enables;
  logic array_rd;
  logic [4:0] ftest;
  logic [15:0] n_arr_rd = 16'h0;
  // counts array read requests seen by the array
  always @(posedge clk) if (array_rd === 1'b1) n_arr_rd <= n_arr_rd + 16'h1;
  int n_errors = 0;
  int n_compared = 0;
  fpe_if bus_if (.clk(clk), .arst_n(arst_n));
  fpe_core_port fpe_core_port_inst (.bus(bus_if), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  fpe_flash_ctrl fpe_flash_ctrl_inst (.bus(bus_if), .test_mode(1'b0), .run_abort(run_abort),
    .array_rdata(16'h5a5a), .array_rd(array_rd), .reg_mode(reg_mode), .run_active(run_active),
    .op_go(op_go), .op_sel(op_sel), .margin_sel(margin_sel), .sector_enables(sector_enables),
    .program_address_latch(pal), .program_data_latch(pdl), .flash_test(ftest));
  fpe_chk fpe_chk_inst (.clk(clk), .arst_n(arst_n), .io_sel(bus_if.io_sel),
    .mem_sel(bus_if.mem_sel), .wr(bus_if.wr), .rd(bus_if.rd), .addr(bus_if.addr),
    .wdata(bus_if.wdata), .rdata(bus_if.rdata));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input fpe_pkg::fpe_cmd_e k, input logic [15:0] a, input logic [15:0] d);
    int i;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    for (i = 0; i < 8 && rsp_valid !== 1'b1; i++) @(posedge clk);
    #1;
  endtask
  task automatic io_o(); cmd(fpe_pkg::FPE_CMD_IO_OUT, 16'hff0f, 16'h0); endtask
  task automatic io_i(); cmd(fpe_pkg::FPE_CMD_IO_IN, 16'hff0f, 16'h0); endtask
  task automatic mw(input logic [15:0] a, d); cmd(fpe_pkg::FPE_CMD_MEM_WR, a, d); endtask
  task automatic mr(input logic [15:0] a); cmd(fpe_pkg::FPE_CMD_MEM_RD, a, 16'h0); endtask
  task automatic t_mode();
    io_o();
    check({15'h0, reg_mode}, 16'h0001);
    mr(16'h8004);
    check(rsp_data, 16'h0);
    io_i();
    check({15'h0, reg_mode}, 16'h0000);
    mw(16'h8123, 16'hffff);
    check(pal, 16'h8123);
    check(pdl, 16'hffff);
    mr(16'h8123);
    check(rsp_data, 16'h5a5a);
  endtask
  task automatic t_fields();
    logic [1:0] v;
    io_o();
    for (int i = 0; i < 4; i++) begin
      v = i[1:0];
      mw({12'h810, v, 2'h0}, {11'h0, v, v, 1'b0});
      check({14'h0, op_sel}, {14'h0, v});
      check({14'h0, margin_sel}, {14'h0, v});
    end
    mw(16'h800e, 16'h1357);
    mr(16'h8002);
    check(rsp_data, 16'h1357);
    mr(16'h8005);
    check(rsp_data, 16'h0);
    mw(16'h8001, 16'h001f);
    check({11'h0, ftest}, 16'h0000);
  endtask
  task automatic t_run();
    mw(16'h8000, 16'h01a3);
    check({15'h0, run_active}, 16'h0000);
    mw(16'h8010, 16'h01c3);
    check({15'h0, run_active}, 16'h0001);
    check({15'h0, op_go}, 16'h0001);
    mr(16'h8000);
    check(rsp_data, 16'h0103);
    mw(16'h8000, 16'hfe1d);
    check({8'h0, sector_enables}, 16'h0001);
    mw(16'h8003, 16'h0000);
    mr(16'h8003);
    check(rsp_data, 16'hffff);
    io_i();
    mr(16'h8040);
    check(rsp_data, 16'h0);
    check(n_arr_rd, 16'h0001);
    io_o();
    @(posedge clk) run_abort <= 1'b1;
    mr(16'h8000);
    check({15'h0, op_go}, 16'h0000);
    @(posedge clk) run_abort <= 1'b0;
    mw(16'h8000, 16'h0040);
    check({15'h0, run_active}, 16'h0000);
    // erase must not start once the data latch no longer holds the fill value, nor a write with no sector enabled
    mw(16'h8003, 16'h0000);
    mw(16'h8000, 16'h0143);
    check({15'h0, op_go}, 16'h0000);
    mw(16'h8000, 16'h0040);
    mw(16'h8000, 16'h0045);
    check({15'h0, op_go}, 16'h0000);
  endtask
  task automatic results();
    $display("errors=%0d compared=%0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #50000;
    n_errors++;
    results();
  end
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_mode();
    t_fields();
    t_run();
    results();
  end
endmodule
